// [dcbo_top.sv]
// disk controller option logic: autoboot, unit decode, dma options, vector
`timescale 1ns/1ps
`include "dcbo_params.svh"
module dcbo_top #(
	parameter logic [35:0] P_BOOT_TIMEOUT_CYC = 36'(`DCBO_BOOT_TIMEOUT_CYC)
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// option switch and strap pins
	input wire dcbo_pkg::dcbo_sw_t i_switches,
	// host register access
	input wire logic [17:0] i_bus_addr,
	input wire logic i_bus_rd,
	input wire logic i_bus_wr,
	input wire logic [15:0] i_bus_wdata,
	output logic [15:0] o_bus_rdata,
	output logic o_bus_ack,
	// controller core: boot and dma
	input wire logic i_unit_ok,
	input wire logic i_burst_end,
	input wire logic [21:0] i_dma_addr,
	output logic o_boot_req,
	output logic [1:0] o_boot_unit,
	output logic o_boot_go,
	output logic o_host_halt,
	output logic o_ctrl_run,
	output logic [3:0] o_first_unit,
	output logic o_wide_addr,
	output logic [21:0] o_dma_addr,
	output logic o_burst_allow,
	// interrupt request and grant chain
	input wire logic i_int_req,
	input wire logic i_grant_in,
	output logic o_int_request,
	output logic o_grant_out,
	output logic o_vec_valid,
	output logic [15:0] o_int_vector
);

	dcbo_pkg::dcbo_state_t r;
	dcbo_pkg::dcbo_state_t next_r;
	dcbo_pkg::dcbo_pins_t pins_s;
	logic hit_vec;
	logic hit_err;
	logic [17:0] base;

	// base address table, also used by the checks below
	function automatic logic [17:0] base_of(input logic [2:0] sel);
		logic [17:0] b;
		b = `DCBO_BASE_0;
		unique case (sel)
			3'h0: b = `DCBO_BASE_0;
			3'h1: b = `DCBO_BASE_1;
			3'h2: b = `DCBO_BASE_2;
			3'h3: b = `DCBO_BASE_3;
			3'h4: b = `DCBO_BASE_4;
			3'h5: b = `DCBO_BASE_5;
			3'h6: b = `DCBO_BASE_6;
			3'h7: b = `DCBO_BASE_7;
		endcase
		return b;
	endfunction

	// alternate first unit: binary, lowest switch first, zero reads as eight
	function automatic logic [3:0] first_unit_of(input logic [2:0] u);
		return (u == 3'h0) ? `DCBO_FIRST_UNIT_ZERO : {1'b0, u};
	endfunction

	dcbo_sync u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_pins({i_switches, i_grant_in}),
		.o_pins(pins_s)
	);

	// address decode against the latched base
	assign base = base_of(r.sw.addr_select);
	assign hit_vec = (i_bus_addr == base + `DCBO_OFS_VECTOR);
	assign hit_err = (i_bus_addr == base + `DCBO_OFS_BOOT_ERR);

	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		next_r.vec_valid = 1'b0;
		next_r.boot_go = 1'b0;
		// run/halt switch wins over the state machine, gap and interrupt logic; latched options are kept
		if (pins_s.sw.run_halt_switch) begin
			next_r.fsm = dcbo_pkg::ST_HALT;
			next_r.settle = `DCBO_SETTLE;
			next_r.gap_cnt = '0;
			next_r.irq_pend = 1'b0;
		end else begin
			unique case (r.fsm)
				dcbo_pkg::ST_HALT: begin
					next_r.fsm = dcbo_pkg::ST_SETTLE;
					next_r.settle = `DCBO_SETTLE;
				end
				dcbo_pkg::ST_SETTLE: begin
					// latch once, after the synchroniser has filled
					next_r.settle = r.settle - 2'h1;
					if (r.settle == 2'h0) begin
						next_r.sw = pins_s.sw;
						next_r.err = `DCBO_ERR_NONE;
						next_r.boot_timer = P_BOOT_TIMEOUT_CYC;
						// autoboot only at the standard address, units 0..3
						if ((pins_s.sw.autoboot_enable_switch | pins_s.sw.alt_autoboot_switch)
								&& pins_s.sw.addr_select == `DCBO_STD_SEL
								&& !pins_s.sw.unit_select[2]) begin
							next_r.fsm = dcbo_pkg::ST_BOOT;
						end else begin
							next_r.fsm = dcbo_pkg::ST_RUN;
						end
					end
				end
				dcbo_pkg::ST_BOOT: begin
					// a dead unit never reports ok, so only the timer or the run/halt switch ends this
					if (i_unit_ok) begin
						next_r.fsm = dcbo_pkg::ST_RUN;
						next_r.boot_go = 1'b1;
					end else if (r.boot_timer <= 36'h1) begin
						next_r.fsm = dcbo_pkg::ST_FAILED;
						next_r.err = `DCBO_ERR_BOOT;
					end else begin
						next_r.boot_timer = r.boot_timer - 36'h1;
					end
				end
				dcbo_pkg::ST_RUN, dcbo_pkg::ST_FAILED: begin
				end
				default: next_r.fsm = dcbo_pkg::ST_HALT;
			endcase
			// burst gap: reload on each burst end, counted down to zero
			if (i_burst_end) begin
				next_r.gap_cnt = r.sw.burst_gap_switch ? `DCBO_GAP_LONG_CYC
					: `DCBO_GAP_SHORT_CYC;
			end else if (r.gap_cnt != 11'h000) begin
				next_r.gap_cnt = r.gap_cnt - 11'h001;
			end
			// interrupt: a new request beats the clear made by a grant
			if (pins_s.grant_in && r.irq_pend && !r.grant_own) begin
				next_r.vec_valid = 1'b1;
				next_r.grant_own = 1'b1;
				next_r.irq_pend = 1'b0;
			end
			if (!pins_s.grant_in) begin
				next_r.grant_own = 1'b0;
			end
			if (i_int_req) begin
				next_r.irq_pend = 1'b1;
			end
		end
		// dma address: upper lines forced low unless wide mode is usable
		// mask follows the switches latched on this same edge, so o_wide_addr agrees
		next_r.dma_addr = (next_r.sw.ext_addr_fitted && next_r.sw.wide_address_switch)
			? i_dma_addr : (i_dma_addr & `DCBO_NARROW_MASK);
		// register access; unmapped addresses get no answer, as on the bus
		if (i_bus_wr && hit_vec) begin
			next_r.vector = i_bus_wdata;
			next_r.ack = 1'b1;
		end else if (i_bus_wr && hit_err) begin
			// a failure raised on this same edge outlives the host's clear
			if (next_r.fsm != dcbo_pkg::ST_FAILED || r.fsm == dcbo_pkg::ST_FAILED) begin
				next_r.err = `DCBO_ERR_NONE; // host acknowledges the code
			end
			next_r.ack = 1'b1;
		end else if (i_bus_rd && (hit_vec || hit_err)) begin
			next_r.rdata = hit_err ? r.err : r.vector;
			next_r.ack = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '0;
			r.fsm <= dcbo_pkg::ST_HALT;
			r.vector <= `DCBO_VECTOR_RST;
			r.err <= `DCBO_ERR_NONE;
		end else begin
			r <= next_r;
		end
	end

	// outputs
	assign o_bus_rdata = r.rdata;
	assign o_bus_ack = r.ack;
	assign o_boot_req = (r.fsm == dcbo_pkg::ST_BOOT);
	assign o_boot_unit = r.sw.unit_select[1:0];
	assign o_boot_go = r.boot_go;
	assign o_host_halt = (r.fsm == dcbo_pkg::ST_FAILED);
	assign o_ctrl_run = (r.fsm == dcbo_pkg::ST_RUN) || (r.fsm == dcbo_pkg::ST_FAILED);
	assign o_first_unit = first_unit_of(r.sw.unit_select);
	assign o_wide_addr = r.sw.ext_addr_fitted & r.sw.wide_address_switch;
	assign o_dma_addr = r.dma_addr;
	assign o_burst_allow = (r.gap_cnt == 11'h000) && o_ctrl_run;
	assign o_int_request = r.irq_pend;
	// grant passes on unless this board wants it or is holding it
	assign o_grant_out = pins_s.grant_in & !r.irq_pend & !r.grant_own;
	assign o_vec_valid = r.vec_valid;
	assign o_int_vector = r.vector;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	property p_halt_hold;
		pins_s.sw.run_halt_switch |=> (r.fsm == dcbo_pkg::ST_HALT) && !o_ctrl_run;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt switch ignored");

	property p_boot_std;
		o_boot_go |-> r.sw.addr_select == `DCBO_STD_SEL && $past(o_boot_req);
	endproperty
	a_boot_std: assert property (p_boot_std) else $error("boot off standard addr");

	property p_timeout;
		o_boot_req && r.boot_timer == 36'h1 && !i_unit_ok && !pins_s.sw.run_halt_switch
			|=> o_host_halt && !o_boot_req;
	endproperty
	a_timeout: assert property (p_timeout) else $error("boot timeout missed");

	property p_err_read;
		o_host_halt && i_bus_rd && hit_err && !i_bus_wr |=> o_bus_ack && o_bus_rdata == r.err;
	endproperty
	a_err_read: assert property (p_err_read) else $error("error word not readable");

	property p_fail_code;
		$rose(o_host_halt) |-> r.err == `DCBO_ERR_BOOT;
	endproperty
	a_fail_code: assert property (p_fail_code) else $error("no error code on fail");

	property p_unit;
		o_boot_req |-> !r.sw.unit_select[2] && o_boot_unit == r.sw.unit_select[1:0];
	endproperty
	a_unit: assert property (p_unit) else $error("boot unit decode wrong");

	property p_first;
		o_first_unit >= 4'h1 && o_first_unit <= 4'h8;
	endproperty
	a_first: assert property (p_first) else $error("first unit out of range");

	property p_wide;
		o_dma_addr[21:18] != 4'h0 |-> o_wide_addr;
	endproperty
	a_wide: assert property (p_wide) else $error("wide address not enabled");

	property p_gap;
		$fell(o_burst_allow) && !pins_s.sw.run_halt_switch && o_ctrl_run
			|-> !o_burst_allow [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("burst gap too short");

	property p_vec;
		o_vec_valid |-> $past(r.irq_pend) && o_int_vector == r.vector && !o_grant_out;
	endproperty
	a_vec: assert property (p_vec) else $error("vector sent without request");

	property p_grant;
		pins_s.grant_in && r.irq_pend |-> !o_grant_out ##1 (o_vec_valid || !r.irq_pend
			|| !pins_s.grant_in || r.grant_own);
	endproperty
	a_grant: assert property (p_grant) else $error("grant passed while pending");

	property p_ack_mapped;
		o_bus_ack |-> $past(hit_vec || hit_err);
	endproperty
	a_ack_mapped: assert property (p_ack_mapped) else $error("unmapped access answered");

	property p_latched;
		(r.fsm != dcbo_pkg::ST_HALT) && (r.fsm != dcbo_pkg::ST_SETTLE)
			&& $past(r.fsm) != dcbo_pkg::ST_SETTLE |-> $stable(r.sw);
	endproperty
	a_latched: assert property (p_latched) else $error("switches changed while running");

	c_boot_ok: cover property (o_boot_req ##1 o_boot_go);
	c_boot_fail: cover property ($rose(o_host_halt));
	c_irq: cover property (o_int_request ##[1:4] o_vec_valid);
	c_gap: cover property ($fell(o_burst_allow) ##[1:1000] o_burst_allow);

endmodule

// [dcbo_params.svh]
// option logic constants: addresses, decodes, timing counts
`ifndef DCBO_PARAMS_SVH
`define DCBO_PARAMS_SVH

// clock
`define DCBO_CLK_NS 5
// register offsets from the base address, in bytes
`define DCBO_OFS_VECTOR 18'h00000
`define DCBO_OFS_BOOT_ERR 18'h00002
// bus base addresses picked by the address-select switches
`define DCBO_BASE_0 18'h3F468
`define DCBO_BASE_1 18'h3F46C
`define DCBO_BASE_2 18'h3E0DC
`define DCBO_BASE_3 18'h3E0E0
`define DCBO_BASE_4 18'h3E0E4
`define DCBO_BASE_5 18'h3E0E8
`define DCBO_BASE_6 18'h3E0EC
`define DCBO_BASE_7 18'h3E0F0
`define DCBO_STD_SEL 3'h0
// reset values and the boot failure code
`define DCBO_VECTOR_RST 16'h0000
`define DCBO_ERR_NONE 16'h0000
`define DCBO_ERR_BOOT 16'h8001
// alternate first-unit decode: all-zero switches mean eight
`define DCBO_FIRST_UNIT_ZERO 4'h8
// narrow dma address mask (18 bits kept)
`define DCBO_NARROW_MASK 22'h03FFFF
// settle cycles after run is released before switches are latched
`define DCBO_SETTLE 2'h3
// boot timeout and burst gaps in their own units
`define DCBO_BOOT_TIMEOUT_S 60
`define DCBO_GAP_SHORT_NS 4000
`define DCBO_GAP_LONG_NS 8000
// cycle counts derived from the clock period (least times round up)
`define DCBO_BOOT_TIMEOUT_CYC \
	((64'd`DCBO_BOOT_TIMEOUT_S * 64'd1000000000) / 64'd`DCBO_CLK_NS)
`define DCBO_GAP_SHORT_CYC \
	11'((`DCBO_GAP_SHORT_NS + `DCBO_CLK_NS - 1) / `DCBO_CLK_NS)
`define DCBO_GAP_LONG_CYC \
	11'((`DCBO_GAP_LONG_NS + `DCBO_CLK_NS - 1) / `DCBO_CLK_NS)

`endif

// [dcbo_pkg.sv]
// types of the disk controller option logic
package dcbo_pkg;

	typedef enum logic [2:0] {
		ST_HALT,
		ST_SETTLE,
		ST_BOOT,
		ST_RUN,
		ST_FAILED
	} dcbo_fsm_t;

	// option switches as seen after synchronisation
	typedef struct packed {
		logic run_halt_switch;
		logic [2:0] unit_select;
		logic autoboot_enable_switch;
		logic alt_autoboot_switch;
		logic [2:0] addr_select;
		logic wide_address_switch;
		logic burst_gap_switch;
		logic ext_addr_fitted;
	} dcbo_sw_t;

	// pin inputs passed through the synchroniser
	typedef struct packed {
		dcbo_sw_t sw;
		logic grant_in;
	} dcbo_pins_t;

	typedef struct packed {
		dcbo_pins_t s1;
		dcbo_pins_t s2;
	} dcbo_sync_st_t;

	typedef struct packed {
		dcbo_fsm_t fsm;
		logic [1:0] settle;
		dcbo_sw_t sw;
		logic [35:0] boot_timer;
		logic [10:0] gap_cnt;
		logic [15:0] err;
		logic [15:0] vector;
		logic irq_pend;
		logic grant_own;
		logic [15:0] rdata;
		logic ack;
		logic [21:0] dma_addr;
		logic vec_valid;
		logic boot_go;
	} dcbo_state_t;

endpackage

// [dcbo_sync.sv]
// two-stage synchroniser for switch and grant pins
`timescale 1ns/1ps
module dcbo_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// pins in, synchronised copy out
	input wire dcbo_pkg::dcbo_pins_t i_pins,
	output dcbo_pkg::dcbo_pins_t o_pins
);

	dcbo_pkg::dcbo_sync_st_t r;
	dcbo_pkg::dcbo_sync_st_t next_r;

	// first stage feeds only the second
	always_comb begin
		next_r.s1 = i_pins;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_pins = r.s2;

endmodule

// [dcbo_host.sv]
// host processor model: register bus master and interrupt grant source
`timescale 1ns/1ps
module dcbo_host (
	// clock
	input wire logic i_clk,
	// register bus
	output logic [17:0] o_bus_addr,
	output logic o_bus_rd,
	output logic o_bus_wr,
	output logic [15:0] o_bus_wdata,
	input wire logic [15:0] i_bus_rdata,
	input wire logic i_bus_ack,
	// grant chain
	output logic o_grant
);
	initial begin
		o_bus_addr = 18'h00000;
		o_bus_rd = 1'b0;
		o_bus_wr = 1'b0;
		o_bus_wdata = 16'h0000;
		o_grant = 1'b0;
	end

	// one word access, held until ack is sampled high or for at most 8 cycles
	task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 16'h0000;
		@(negedge i_clk);
		o_bus_addr = a;
		o_bus_wdata = d;
		o_bus_rd = !wr;
		o_bus_wr = wr;
		for (n = 0; n < 8 && !ok; n++) begin
			@(posedge i_clk);
			if (i_bus_ack === 1'b1) begin
				ok = 1'b1;
				q = i_bus_rdata;
			end
		end
		@(negedge i_clk);
		o_bus_rd = 1'b0;
		o_bus_wr = 1'b0;
		// released lines show inverted values so stale data never matches
		o_bus_addr = ~a;
		o_bus_wdata = ~d;
		// idle cycles let the repeat ack of a level strobe drain
		repeat (2) @(negedge i_clk);
	endtask

	// grant level from the processor, changed off the sampling edge
	task automatic grant(input logic lvl);
		@(negedge i_clk);
		o_grant = lvl;
	endtask
endmodule

// [tb_top.sv]
// self-checking bench for the disk controller option logic
`timescale 1ns/1ps
module tb_top;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	dcbo_pkg::dcbo_sw_t sw;
	logic [17:0] bus_addr;
	logic bus_rd, bus_wr, bus_ack, unit_ok, burst_end, int_req, grant_in;
	logic [15:0] bus_wdata, bus_rdata, int_vector, q;
	logic boot_req, boot_go, host_halt, ctrl_run, wide_addr, burst_allow;
	logic int_request, grant_out, vec_valid, ok;
	logic [1:0] boot_unit;
	logic [3:0] first_unit;
	logic [21:0] dma_addr;
	logic [21:0] dma_in = 22'h3FFFFF;
	int fail_count = 0;
	int compares = 0;
	int n;

	// 200 MHz
	always #2.5 i_clk = ~i_clk;

	dcbo_top #(.P_BOOT_TIMEOUT_CYC(36'd50)) DUT (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_switches(sw), .i_bus_addr(bus_addr), .i_bus_rd(bus_rd), .i_bus_wr(bus_wr),
		.i_bus_wdata(bus_wdata), .o_bus_rdata(bus_rdata), .o_bus_ack(bus_ack),
		.i_unit_ok(unit_ok), .i_burst_end(burst_end), .i_dma_addr(dma_in),
		.o_boot_req(boot_req), .o_boot_unit(boot_unit), .o_boot_go(boot_go),
		.o_host_halt(host_halt), .o_ctrl_run(ctrl_run), .o_first_unit(first_unit),
		.o_wide_addr(wide_addr), .o_dma_addr(dma_addr), .o_burst_allow(burst_allow),
		.i_int_req(int_req), .i_grant_in(grant_in), .o_int_request(int_request),
		.o_grant_out(grant_out), .o_vec_valid(vec_valid), .o_int_vector(int_vector));

	dcbo_host host (.i_clk(i_clk), .o_bus_addr(bus_addr), .o_bus_rd(bus_rd),
		.o_bus_wr(bus_wr), .o_bus_wdata(bus_wdata), .i_bus_rdata(bus_rdata),
		.i_bus_ack(bus_ack), .o_grant(grant_in));

	task automatic finish_test();
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [21:0] got, input logic [21:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// a wait ran out of its bound
	task automatic tmo();
		fail_count++;
		finish_test();
	endtask

	function automatic dcbo_pkg::dcbo_sw_t mk(input logic [2:0] u, input logic ab,
		input logic [2:0] as, input logic w, input logic g, input logic e);
		return {1'b0, u, ab, 1'b0, as, w, g, e};
	endfunction

	// halt, change switches, release so they are sampled afresh
	task automatic relatch(input dcbo_pkg::dcbo_sw_t s);
		@(negedge i_clk);
		sw.run_halt_switch = 1'b1;
		repeat (4) @(negedge i_clk);
		sw = s;
	endtask

	task automatic wait_boot();
		for (n = 0; n < 40 && boot_req !== 1'b1; n++) @(posedge i_clk);
		if (n == 40) tmo();
	endtask

	task automatic boot_ok();
		wait_boot();
		chk(boot_unit, 22'h3);
		@(negedge i_clk);
		unit_ok = 1'b1;
		for (n = 0; n < 10 && boot_go !== 1'b1; n++) @(posedge i_clk);
		if (n == 10) tmo();
		@(negedge i_clk);
		unit_ok = 1'b0;
		chk({ctrl_run, host_halt}, 22'h2);
	endtask

	task automatic boot_fail();
		dcbo_pkg::dcbo_sw_t s;
		// the second autoboot switch alone must start the boot as well
		s = mk(3'h1, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
		s.alt_autoboot_switch = 1'b1;
		relatch(s);
		wait_boot();
		chk(boot_unit, 22'h1);
		for (n = 0; n < 200 && host_halt !== 1'b1; n++) @(posedge i_clk);
		if (n == 200) tmo();
		chk(22'(n >= 48 && n <= 52), 22'h1);
		host.access(1'b0, 18'h3F46A, 16'h0000, q, ok);
		chk({ok, q}, 22'h18001);
		host.access(1'b1, 18'h3F46A, 16'h1234, q, ok);
		host.access(1'b0, 18'h3F46A, 16'h0000, q, ok);
		chk({ok, q}, 22'h10000);
	endtask

	// every unit code at an alternate base; zero means eight
	task automatic alt_units();
		for (int u = 0; u < 8; u++) begin
			relatch(mk(3'(u), 1'b1, 3'h1, 1'b0, 1'b0, 1'b0));
			repeat (12) @(negedge i_clk);
			chk(first_unit, (u == 0) ? 22'h8 : 22'(u));
			chk(boot_req, 22'h0);
		end
	endtask

	task automatic regs();
		host.access(1'b1, 18'h3F46C, 16'hA5C3, q, ok);
		host.access(1'b0, 18'h3F46C, 16'h0000, q, ok);
		chk({ok, q}, 22'h1A5C3);
		host.access(1'b0, 18'h3F46E, 16'h0000, q, ok);
		chk({ok, q}, 22'h10000);
		host.access(1'b0, 18'h3F468, 16'h0000, q, ok);
		chk(ok, 22'h0);
		host.access(1'b0, 18'h3F470, 16'h0000, q, ok);
		chk(ok, 22'h0);
	endtask

	// both gap settings, each paired with a dma address width
	task automatic gaps();
		for (int g = 0; g < 2; g++) begin
			dma_in = g ? 22'h2ABCDE : 22'h3C1234;
			relatch(mk(3'h4, 1'b0, 3'h1, 1'b1, 1'(g), 1'(g)));
			repeat (12) @(negedge i_clk);
			chk(wide_addr, 22'(g));
			chk(dma_addr, g ? 22'h2ABCDE : 22'h001234);
			burst_end = 1'b1;
			@(negedge i_clk);
			burst_end = 1'b0;
			for (n = 0; n < 2000; n++) begin
				@(posedge i_clk);
				if (burst_allow === 1'b1) break;
			end
			if (n == 2000) tmo();
			chk(22'(n), g ? 22'd1600 : 22'd800);
		end
	endtask

	task automatic irq();
		host.grant(1'b1);
		repeat (4) @(negedge i_clk);
		chk(grant_out, 22'h1);
		host.grant(1'b0);
		repeat (4) @(negedge i_clk);
		int_req = 1'b1;
		@(negedge i_clk);
		int_req = 1'b0;
		chk(int_request, 22'h1);
		host.grant(1'b1);
		for (n = 0; n < 10 && vec_valid !== 1'b1; n++) @(posedge i_clk);
		if (n == 10) tmo();
		chk(int_vector, 22'hA5C3);
		@(negedge i_clk);
		chk({int_request, grant_out}, 22'h0);
		host.grant(1'b0);
	endtask

	initial begin
		sw = mk(3'h3, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
		unit_ok = 1'b0;
		burst_end = 1'b0;
		int_req = 1'b0;
		repeat (12) @(negedge i_clk);
		i_nrst = 1'b1;
		boot_ok();
		boot_fail();
		alt_units();
		regs();
		gaps();
		irq();
		finish_test();
	end
endmodule
